//--- rrof_pkg.sv
// Function
// - dual rail: each negative line pulse drives the negative output high one period
// - dual rail: negative data only on negative output, positive only on positive output
// - single rail: negative output flags code violation or excess zeros, one period minimum
// - negative or violation output changes only at the recovered clock active edge
// - recovered clock output provided; both data outputs launched at its active edge
// - single rail: violation flag updated at recovered clock edge, aligned with data
// - tip above ring is a positive pulse; ring above tip is a negative pulse
// - dual rail: each positive line pulse drives the positive output high one period
// - single rail: all recovered data appears on the positive output alone
`default_nettype none
package rrof_pkg;
  // core clock and recovered clock timing
  localparam int CORE_CLK_PERIOD_NS = 100;
  localparam int RECOV_PERIOD_NS    = 800;
  localparam int RECOV_PERIOD_CYC   = (RECOV_PERIOD_NS / CORE_CLK_PERIOD_NS < 2) ? 2 :
                                      RECOV_PERIOD_NS / CORE_CLK_PERIOD_NS;
  localparam int RECOV_HIGH_CYC     = RECOV_PERIOD_CYC / 2;
  // buffered word layout
  localparam int WORD_W             = 2;
  localparam int POS_BIT            = 1;
  localparam int NEG_BIT            = 0;
  localparam int FIFO_DEPTH         = 4;
  // zeros in a row that count as an excess zeros event
  localparam int ZERO_LIMIT         = 3;
  // synchroniser layout and reset values
  localparam int SYNC_W             = 4;
  localparam int SYNC_CLK           = 3;
  localparam int SYNC_PLUS          = 2;
  localparam int SYNC_MINUS         = 1;
  localparam int SYNC_MODE          = 0;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 4'h0;
endpackage
`default_nettype wire

//--- rrof_sync.sv
`timescale 1ns/100ps
`default_nettype none
module rrof_sync #(
  parameter int WIDTH = rrof_pkg::SYNC_W
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // two flip-flop synchroniser; the first stage feeds only the second
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= asyncIn;
      sync_q <= meta_q;
    end
  end

  assign syncOut = sync_q;
endmodule
`default_nettype wire

//--- rrof_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module rrof_fifo #(
  parameter int WIDTH = rrof_pkg::WORD_W,
  parameter int DEPTH = rrof_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // filling side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // draining side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = (DEPTH < 2) ? 1 : $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr_q;
  logic [AW:0]      wrPtr_d;
  logic [AW:0]      rdPtr_q;
  logic [AW:0]      rdPtr_d;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  // flags and pointer advance; depth is a power of two
  always_comb begin
    full    = (wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
    empty   = (wrPtr_q == rdPtr_q);
    push    = inValid && !full;
    pop     = outReady && !empty;
    wrPtr_d = wrPtr_q + {{AW{1'b0}}, push};
    rdPtr_d = rdPtr_q + {{AW{1'b0}}, pop};
  end

  // pointer registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
    end
  end

  // storage, written only on an accepted push
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr_q[AW-1:0]] <= inData;
    end
  end

  assign inReady  = !full;
  assign outValid = !empty;
  assign outData  = mem[rdPtr_q[AW-1:0]];
endmodule
`default_nettype wire

//--- rrof_formatter.sv
`timescale 1ns/100ps
`default_nettype none
module rrof_formatter #(
  parameter int PERIOD_CYC = rrof_pkg::RECOV_PERIOD_CYC,
  parameter int HIGH_CYC   = rrof_pkg::RECOV_HIGH_CYC,
  parameter int ZERO_LIMIT = rrof_pkg::ZERO_LIMIT,
  parameter int FIFO_DEPTH = rrof_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // line side, from the slicer behind the transformer
  input  wire logic lineClkIn,
  input  wire logic line_in_plus,
  input  wire logic line_in_minus,
  // configuration
  input  wire logic singleRailMode,
  // system side, toward the framer
  output logic      recovered_clock_out,
  output logic      rx_pos_data,
  output logic      rx_neg_or_violation,
  // status
  output logic      overrun
);
  localparam int CW = $clog2(PERIOD_CYC + 1);
  localparam int ZW = $clog2(ZERO_LIMIT + 1);
  localparam logic [CW-1:0] LAST_CNT = CW'(PERIOD_CYC - 1);
  localparam logic [CW-1:0] HIGH_CNT = CW'(HIGH_CYC);
  localparam logic [ZW-1:0] ZERO_LAST = ZW'(ZERO_LIMIT - 1);

  logic [rrof_pkg::SYNC_W-1:0] syncLvl;
  logic                        lineClkS;
  logic                        plusS;
  logic                        minusS;
  logic                        singleS;

  // line clock, line levels and mode all come from outside this clock domain
  rrof_sync #(
    .WIDTH (rrof_pkg::SYNC_W)
  ) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .asyncIn  ({lineClkIn, line_in_plus, line_in_minus, singleRailMode}),
    .syncOut  (syncLvl)
  );

  assign lineClkS = syncLvl[rrof_pkg::SYNC_CLK];
  assign plusS    = syncLvl[rrof_pkg::SYNC_PLUS];
  assign minusS   = syncLvl[rrof_pkg::SYNC_MINUS];
  // dual after reset
  // the synchroniser clears to zero, so a fresh reset always starts in dual rail
  assign singleS  = syncLvl[rrof_pkg::SYNC_MODE];

  // line sampling and decoding
  logic                          lineClkPrev_q;
  logic                          lineClkPrev_d;
  logic                          hadPulse_q;
  logic                          hadPulse_d;
  logic                          lastPos_q;
  logic                          lastPos_d;
  logic [ZW-1:0]                 zeroCnt_q;
  logic [ZW-1:0]                 zeroCnt_d;
  logic                          pendValid_q;
  logic                          pendValid_d;
  logic [rrof_pkg::WORD_W-1:0]   pendWord_q;
  logic [rrof_pkg::WORD_W-1:0]   pendWord_d;
  logic                          overrun_q;
  logic                          overrun_d;
  logic                          lineEdge;
  logic                          pulsePos;
  logic                          pulseNeg;
  logic                          pulseAny;
  logic                          code_violation;
  logic                          excess_zeros_event;
  logic [rrof_pkg::WORD_W-1:0]   word;
  logic                          fifoInReady;
  logic                          fifoOutValid;
  logic [rrof_pkg::WORD_W-1:0]   fifoOutData;
  logic                          launch;

  // classify the bit cell and build the buffered word
  always_comb begin
    lineEdge    = lineClkS && !lineClkPrev_q;
    pulsePos    = plusS && !minusS;
    pulseNeg    = minusS && !plusS;
    pulseAny    = pulsePos || pulseNeg;
    code_violation     = pulseAny && hadPulse_q && (pulsePos == lastPos_q);
    excess_zeros_event = !pulseAny && (zeroCnt_q == ZERO_LAST);
    word        = '0;
    if (singleS) begin
      word[rrof_pkg::POS_BIT] = pulseAny;
      word[rrof_pkg::NEG_BIT] = code_violation || excess_zeros_event;
    end else begin
      word[rrof_pkg::POS_BIT] = pulsePos;
      word[rrof_pkg::NEG_BIT] = pulseNeg;
    end
    lineClkPrev_d = lineClkS;
    hadPulse_d    = hadPulse_q;
    lastPos_d     = lastPos_q;
    zeroCnt_d     = zeroCnt_q;
    pendValid_d   = pendValid_q && !fifoInReady;
    pendWord_d    = pendWord_q;
    overrun_d     = overrun_q;
    if (lineEdge) begin
      if (pulseAny) begin
        hadPulse_d = 1'b1;
        lastPos_d  = pulsePos;
        zeroCnt_d  = '0;
      end else if (zeroCnt_q != ZERO_LAST) begin
        zeroCnt_d = zeroCnt_q + ZW'(1);
      end else begin
        zeroCnt_d = '0;
      end
      // a word still waiting on back-pressure is replaced and flagged
      if (pendValid_d) begin
        overrun_d = 1'b1;
      end
      pendValid_d = 1'b1;
      pendWord_d  = word;
    end
  end

  // sampling registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lineClkPrev_q <= 1'b0;
      hadPulse_q    <= 1'b0;
      lastPos_q     <= 1'b0;
      zeroCnt_q     <= '0;
      pendValid_q   <= 1'b0;
      pendWord_q    <= '0;
      overrun_q     <= 1'b0;
    end else begin
      lineClkPrev_q <= lineClkPrev_d;
      hadPulse_q    <= hadPulse_d;
      lastPos_q     <= lastPos_d;
      zeroCnt_q     <= zeroCnt_d;
      pendValid_q   <= pendValid_d;
      pendWord_q    <= pendWord_d;
      overrun_q     <= overrun_d;
    end
  end

  // elastic buffer between line sampling and recovered clock launch
  rrof_fifo #(
    .WIDTH (rrof_pkg::WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .inValid  (pendValid_q),
    .inReady  (fifoInReady),
    .inData   (pendWord_q),
    .outValid (fifoOutValid),
    .outReady (launch),
    .outData  (fifoOutData)
  );

  // recovered clock and output launch
  logic [CW-1:0] divCnt_q;
  logic [CW-1:0] divCnt_d;
  logic          clkOut_q;
  logic          clkOut_d;
  logic          rx_pos_data_q;
  logic          rx_pos_data_d;
  logic          rxNeg_q;
  logic          rxNeg_d;

  // divider makes the clock; rising edge and data launch share one core edge
  always_comb begin
    launch   = (divCnt_q == LAST_CNT);
    divCnt_d = launch ? '0 : divCnt_q + CW'(1);
    // recovered clock out
    // the rise is tied to launch, so no bare rise follows reset
    clkOut_d = launch || (clkOut_q && (divCnt_d < HIGH_CNT));
    rx_pos_data_d  = rx_pos_data_q;
    rxNeg_d  = rxNeg_q;
    if (launch) begin
      rx_pos_data_d = fifoOutValid && fifoOutData[rrof_pkg::POS_BIT];
      rxNeg_d = fifoOutValid && fifoOutData[rrof_pkg::NEG_BIT];
    end
  end

  // output registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      divCnt_q <= '0;
      clkOut_q <= 1'b0;
      rx_pos_data_q  <= 1'b0;
      rxNeg_q  <= 1'b0;
    end else begin
      divCnt_q <= divCnt_d;
      clkOut_q <= clkOut_d;
      rx_pos_data_q  <= rx_pos_data_d;
      rxNeg_q  <= rxNeg_d;
    end
  end

  assign recovered_clock_out = clkOut_q;
  assign rx_pos_data         = rx_pos_data_q;
  assign rx_neg_or_violation = rxNeg_q;
  assign overrun             = overrun_q;

  // checks on the formatter's own outputs and words
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence launchWord;
    launch && fifoOutValid;
  endsequence

  sequence dualNegRise;
    $rose(rx_neg_or_violation) && !singleS;
  endsequence

  sequence dualPosRise;
    $rose(rx_pos_data) && !singleS;
  endsequence

  // line cells as the synchroniser presents them at a detected edge
  sequence lineCellNeg;
    lineEdge && minusS && !plusS && !singleS;
  endsequence

  sequence lineCellPos;
    lineEdge && plusS && !minusS && !singleS;
  endsequence

  sequence singleRepeatCell;
    lineEdge && singleS && hadPulse_q && (plusS != minusS) && (plusS == lastPos_q);
  endsequence

  sequence singleZeroRun;
    lineEdge && singleS && (plusS == minusS) && (zeroCnt_q == ZERO_LAST);
  endsequence

  // default period is eight core cycles
  chk_neg_one_period: assert property (dualNegRise |-> rx_neg_or_violation[*8])
    else $error("negative pulse shorter than one recovered period");
  chk_pos_one_period: assert property (dualPosRise |-> rx_pos_data[*8])
    else $error("positive pulse shorter than one recovered period");
  chk_viol_hold: assert property (
    ($rose(rx_neg_or_violation) && singleS) |-> rx_neg_or_violation[*8])
    else $error("violation flag shorter than one recovered period");
  chk_rails_separate: assert property (
    (launchWord ##0 !singleS) |=> !(rx_pos_data && rx_neg_or_violation))
    else $error("both rails high in dual rail mode");
  chk_neg_edge_only: assert property (
    $changed(rx_neg_or_violation) |-> $rose(recovered_clock_out))
    else $error("negative output changed off the clock edge");
  chk_pos_launch: assert property (
    $changed(rx_pos_data) |-> $rose(recovered_clock_out) && $past(launch))
    else $error("positive output changed off the clock edge");
  chk_viol_aligned: assert property (
    launchWord |=> rx_neg_or_violation == $past(fifoOutData[rrof_pkg::NEG_BIT]))
    else $error("violation flag not taken from the launched word");
  chk_data_on_pos: assert property (
    launchWord |=> rx_pos_data == $past(fifoOutData[rrof_pkg::POS_BIT]))
    else $error("data output not taken from the launched word");
  chk_polarity_class: assert property (
    lineCellNeg |=> pendWord_q == 2'h1)
    else $error("ring above tip not classed as negative");
  chk_clock_period: assert property (
    $rose(recovered_clock_out) |-> recovered_clock_out[*4] ##1 !recovered_clock_out[*4])
    else $error("recovered clock shape wrong");

  // tip above ring lands on the positive rail only
  chk_pos_polarity: assert property (
    lineCellPos |=> pendWord_q == 2'h2)
    else $error("tip above ring not classed as positive");

  // a pulse of the same polarity as the one before is a code violation
  chk_viol_flag: assert property (
    singleRepeatCell |=> pendWord_q[rrof_pkg::NEG_BIT])
    else $error("code violation not flagged");

  // every third zero cell in a row carries the excess zeros flag
  chk_zeros_flag: assert property (
    singleZeroRun |=> pendWord_q[rrof_pkg::NEG_BIT])
    else $error("excess zeros not flagged");

  // in single rail a pulse of either polarity is data
  chk_single_data: assert property (
    (lineEdge && singleS) |=> pendWord_q[rrof_pkg::POS_BIT] == $past(plusS != minusS))
    else $error("single rail data not on the positive rail");

  // an empty buffer at launch gives no pulse on either rail
  chk_empty_launch: assert property (
    (launch && !fifoOutValid) |=> !rx_pos_data && !rx_neg_or_violation)
    else $error("output pulse without a received pulse");

  // every launch is a rising edge of the recovered clock
  chk_launch_rise: assert property (
    launch |=> $rose(recovered_clock_out))
    else $error("data launched without a recovered clock rise");

  // the mode synchroniser starts out in dual rail
  chk_mode_reset: assert property (
    $rose(rst_n) |-> !singleS ##1 !singleS)
    else $error("mode not dual rail after reset");
endmodule
`default_nettype wire

//--- rrof_framer_model.sv
`timescale 1ns/100ps
`default_nettype none
module rrof_framer_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // recovered clock and data from the formatter
  input wire logic recClk,
  input wire logic posData,
  input wire logic negData
);
  logic [1:0] words[$];     // one word per recovered clock period
  int         misalignCnt;  // data changes away from a clock rise
  int         badPeriodCnt; // clock periods other than eight cycles
  logic       prevClk;
  logic [1:0] prevData;
  int         periodCnt;

  // counters start clean
  initial begin
    misalignCnt = 0;
    badPeriodCnt = 0;
  end

  // sample at the core clock's falling edge, where the outputs have settled
  always @(negedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prevClk = 1'b0;
      prevData = 2'h0;
      periodCnt = -1;
    end else begin
      if (periodCnt >= 0) periodCnt++;
      // changes only with a clock rise
      if ({posData, negData} !== prevData && !(recClk && !prevClk)) misalignCnt++;
      // capture launched word, time the period
      if (recClk && !prevClk) begin
        if (periodCnt > 0 && periodCnt != 8) badPeriodCnt++;
        periodCnt = 0;
        words.push_back({posData, negData});
      end
      prevClk = recClk;
      prevData = {posData, negData};
    end
  end
endmodule
`default_nettype wire

//--- tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic coreClk;
  logic rstN;
  logic lineClk;
  logic linePlus;
  logic lineMinus;
  logic singleRail;
  logic recClk;
  logic posData;
  logic negData;
  logic overrun;
  int   numErrors   = 0;
  int   totalChecks = 0;
  int   cycles      = 0;

  // design and framer
  rrof_formatter i_dut (
    .core_clk            (coreClk),
    .rst_n               (rstN),
    .lineClkIn           (lineClk),
    .line_in_plus        (linePlus),
    .line_in_minus       (lineMinus),
    .singleRailMode      (singleRail),
    .recovered_clock_out (recClk),
    .rx_pos_data         (posData),
    .rx_neg_or_violation (negData),
    .overrun             (overrun)
  );
  rrof_framer_model i_framer (
    .core_clk (coreClk),
    .rst_n    (rstN),
    .recClk   (recClk),
    .posData  (posData),
    .negData  (negData)
  );

  // core clock, 100 ns
  always #50 coreClk = ~coreClk;

  task automatic close_out();
    if (numErrors == 0 && totalChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // hang guard
  always @(posedge coreClk) begin
    cycles++;
    if (cycles == 4000) begin
      numErrors++;
      close_out();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      numErrors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic do_reset(input logic mode);
    rstN = 1'b0;
    singleRail = mode;
    repeat (10) @(negedge coreClk);
    rstN = 1'b1;
    i_framer.words.delete();
    repeat (4) @(negedge coreClk);
  endtask

  // cells: bit1 tip above ring, bit0 ring above tip; line clock stops after
  task automatic send_cells(input logic [1:0] cells[], input int halfCyc);
    foreach (cells[i]) begin
      linePlus = cells[i][1];
      lineMinus = cells[i][0];
      repeat (halfCyc) @(negedge coreClk);
      lineClk = 1'b1;
      repeat (halfCyc) @(negedge coreClk);
      lineClk = 1'b0;
    end
  endtask

  // stream starts at the first word with the data bit set
  task automatic expect_stream(input string what, input logic [1:0] exp[]);
    int first;
    repeat (64) @(negedge coreClk);
    first = -1;
    foreach (i_framer.words[i]) if (first < 0 && i_framer.words[i][1]) first = i;
    for (int i = 0; i < exp.size(); i++)
      check(what, 8'(i_framer.words[first + i]), 8'(exp[i])); // per cell
  endtask

  task automatic test_dual();
    do_reset(1'b0); // dual rail
    send_cells('{2'h2, 2'h1, 2'h3, 2'h1, 2'h1, 2'h2, 2'h0, 2'h2}, 4);
    expect_stream("dual rail words", '{2'h2, 2'h1, 2'h0, 2'h1, 2'h1, 2'h2, 2'h0, 2'h2});
  endtask

  task automatic test_single();
    do_reset(1'b1); // single rail
    send_cells('{2'h2, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0, 2'h2, 2'h2, 2'h3, 2'h1}, 4);
    expect_stream("single rail words",
                  '{2'h2, 2'h2, 2'h3, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h2});
  endtask

  // line faster than the output: fifo fills and refuses, then drains to zeros
  task automatic test_overrun();
    do_reset(1'b0); // dual rail
    check("overrun after reset", 8'(overrun), 8'h00); // reset state
    // six-cycle cells against an eight-cycle output gain one word every 24 cycles
    repeat (32) send_cells('{2'h2}, 3);
    repeat (4) @(negedge coreClk);
    check("overrun after burst", 8'(overrun), 8'h01); // pulses dropped
    repeat (80) @(negedge coreClk);
    check("outputs after drain", 8'({posData, negData}), 8'h00); // no pulse no output
    check("overrun held", 8'(overrun), 8'h01); // pulses dropped
    do_reset(1'b0); // dual rail
    check("overrun cleared", 8'(overrun), 8'h00); // reset state
  endtask

  // main sequence
  initial begin
    coreClk = 1'b0;
    rstN = 1'b0;
    lineClk = 1'b0;
    linePlus = 1'b0;
    lineMinus = 1'b0;
    singleRail = 1'b0;
    test_dual();
    test_single();
    test_overrun();
    check("misaligned changes", 8'(i_framer.misalignCnt), 8'h00); // edge alignment
    check("bad clock periods", 8'(i_framer.badPeriodCnt), 8'h00); // clock period
    close_out();
  end
endmodule
`default_nettype wire
